// ==== design/ipe_consts.svh ====
// Offsets, field positions, reset values for the pending and priority enable block.
// Assumes inclusion by bare name from design files.
`ifndef IPE_CONSTS_SVH
`define IPE_CONSTS_SVH
`define IPE_IDX_G0_EN_HI 12'hfc1
`define IPE_IDX_G0_EN_LO 12'hfc2
`define IPE_IDX_G2_PEND 12'hfc6
`define IPE_IDX_G0_PEND 12'hfc0
`define IPE_IDX_CTRL 12'hfe0
`define IPE_IDX_STAT 12'hfe1
`define IPE_IDX_VEC 12'hfe2
`define IPE_IDX_IRQ_STAT 12'hfe4
`define IPE_IDX_IRQ_CLR 12'hfe5
`define IPE_IDX_IRQ_EN 12'hfe6
`define IPE_G0_MASK 8'h79
`define IPE_G2_MASK 8'h0f
`define IPE_BIT_TIMER1 6
`define IPE_BIT_TIMER0 5
`define IPE_BIT_SRX 4
`define IPE_BIT_STX 3
`define IPE_BIT_CONV 0
`define IPE_RESET_BYTE 8'h00
`define IPE_EV_G0 0
`define IPE_EV_G2 1
`define IPE_EV_VEC 2
`endif

// ==== design/ipe_irq_ctrl.sv ====
// Group-2 pending register, group-0 pending and enable pairs, vectoring, APB slave.
// Assumes sources are pins (synchronised here) and the core acknowledges on pclk.
//
// How it works
// RQ1 - Port C request sets its pending bit
// RQ2 - Global enable forwards pending as vector; code vectors group-0 pending only, port C pending is never vectored
// RQ3 - Disabled globally, pending still recorded for polling
// RQ4 - Pending bits 3..0 map port C pins
// RQ5 - Software writes zero to bits 7..4
// RQ6 - Code is high bit then low bit
// RQ7 - 00 off, 01 low, 10 nominal, 11 high
// RQ8 - High enable bits 6,5,4,3,0 per source
// RQ9 - Low enable uses same bit assignment
// RQ10 - Software writes zero to bits 2..1
// RQ11 - Low enable bit 7 reads zero
// RQ12 - Group-0 pending matches enable positions
// RQ13 - Reset clears pending and enables
// RQ14 - Highest level presented first, fixed ties
`timescale 1ns/10ps
`include "ipe_consts.svh"
module ipe_irq_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] portc_pin_request,
   input wire logic [7:0] group0_source_request,
   input wire logic vec_ack,
   output logic vec_req,
   output ipe_pkg::ipe_vec_s vec_info,
   output logic irq
);
   import ipe_pkg::*;

   ////////////////////////////////////////////////////////////////
   // Input synchronisers and rising edge detect
   logic [3:0] pc_s1_r, pc_s2_r, pc_s3_r;
   logic [7:0] g0_s1_r, g0_s2_r, g0_s3_r;
   logic [3:0] pc_rise;
   logic [7:0] g0_rise;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_s1_r <= 4'h0;
         pc_s2_r <= 4'h0;
         pc_s3_r <= 4'h0;
         g0_s1_r <= 8'h00;
         g0_s2_r <= 8'h00;
         g0_s3_r <= 8'h00;
      end else begin
         pc_s1_r <= portc_pin_request;
         pc_s2_r <= pc_s1_r;
         pc_s3_r <= pc_s2_r;
         g0_s1_r <= group0_source_request;
         g0_s2_r <= g0_s1_r;
         g0_s3_r <= g0_s2_r;
      end
   end
   assign pc_rise = pc_s2_r & ~pc_s3_r;
   assign g0_rise = g0_s2_r & ~g0_s3_r & `IPE_G0_MASK; // RQ12

   ////////////////////////////////////////////////////////////////
   // Bus decode
   logic wr_en, rd_en;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign pready = 1'b1;
   logic [11:0] idx;
   assign idx = paddr[13:2];
   logic hit;
   always_comb begin
      hit = 1'b1;
      unique case (idx)
         `IPE_IDX_G0_PEND, `IPE_IDX_G0_EN_HI, `IPE_IDX_G0_EN_LO, `IPE_IDX_G2_PEND,
         `IPE_IDX_CTRL, `IPE_IDX_STAT, `IPE_IDX_VEC, `IPE_IDX_IRQ_STAT,
         `IPE_IDX_IRQ_CLR, `IPE_IDX_IRQ_EN: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~hit;

   ////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] g0_pend_r, g0_pend_nxt;
   logic [7:0] g2_pend_r, g2_pend_nxt;
   logic [7:0] en_hi_r, en_hi_nxt;
   logic [7:0] en_lo_r, en_lo_nxt;
   logic gie_r, gie_nxt;
   logic [2:0] ev_stat_r, ev_stat_nxt;
   logic [2:0] ev_en_r, ev_en_nxt;
   logic vec_req_r, vec_req_nxt;
   ipe_vec_s vec_r, vec_nxt;
   ipe_vec_s pick;
   logic [7:0] wb;
   logic take;
   assign wb = pwdata[7:0];
   assign take = vec_req_r & vec_ack;

   ipe_prio_pick #(.N(8)) u_pick (
      .pend(g0_pend_r),
      .en_hi(en_hi_r),
      .en_lo(en_lo_r),
      .pick(pick)
   );

   always_comb begin
      g0_pend_nxt = g0_pend_r;
      g2_pend_nxt = g2_pend_r;
      en_hi_nxt = en_hi_r;
      en_lo_nxt = en_lo_r;
      gie_nxt = gie_r;
      ev_en_nxt = ev_en_r;
      ev_stat_nxt = ev_stat_r;
      vec_req_nxt = vec_req_r;
      vec_nxt = vec_r;
      if (wr_en) begin
         unique case (idx)
            `IPE_IDX_G0_PEND: g0_pend_nxt = wb & `IPE_G0_MASK;
            `IPE_IDX_G2_PEND: g2_pend_nxt = wb & `IPE_G2_MASK; // RQ5
            `IPE_IDX_G0_EN_HI: en_hi_nxt = wb & `IPE_G0_MASK; // RQ8 RQ10
            `IPE_IDX_G0_EN_LO: en_lo_nxt = wb & `IPE_G0_MASK; // RQ9 RQ11
            `IPE_IDX_CTRL: gie_nxt = wb[0];
            `IPE_IDX_IRQ_CLR: ev_stat_nxt = ev_stat_r & ~wb[2:0];
            `IPE_IDX_IRQ_EN: ev_en_nxt = wb[2:0];
            default: ;
         endcase
      end
      // Acknowledged source drops its pending flag
      if (take) begin
         g0_pend_nxt[vec_r.source[2:0]] = 1'b0;
         vec_req_nxt = 1'b0;
      end
      // Hardware set wins over any clear
      g2_pend_nxt = g2_pend_nxt | {4'h0, pc_rise}; // RQ1 RQ3 RQ4
      g0_pend_nxt = g0_pend_nxt | g0_rise; // RQ12
      if (!vec_req_nxt && gie_r && pick.valid && !take) begin // RQ2 RQ14
         vec_req_nxt = 1'b1;
         vec_nxt = pick;
      end
      ev_stat_nxt = ev_stat_nxt | {take, |g2_pend_nxt, |g0_pend_nxt};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         g0_pend_r <= `IPE_RESET_BYTE; // RQ13
         g2_pend_r <= `IPE_RESET_BYTE;
         en_hi_r <= `IPE_RESET_BYTE;
         en_lo_r <= `IPE_RESET_BYTE;
         gie_r <= 1'b0;
         ev_stat_r <= 3'h0;
         ev_en_r <= 3'h0;
         vec_req_r <= 1'b0;
         vec_r <= '0;
      end else begin
         g0_pend_r <= g0_pend_nxt;
         g2_pend_r <= g2_pend_nxt;
         en_hi_r <= en_hi_nxt;
         en_lo_r <= en_lo_nxt;
         gie_r <= gie_nxt;
         ev_stat_r <= ev_stat_nxt;
         ev_en_r <= ev_en_nxt;
         vec_req_r <= vec_req_nxt;
         vec_r <= vec_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read data and outputs
   logic [31:0] rd_nxt, rd_r;
   always_comb begin
      // Hold captured word through the access phase
      rd_nxt = (psel & penable) ? rd_r : 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
         unique case (idx)
            `IPE_IDX_G0_PEND: rd_nxt = {24'h0, g0_pend_r};
            `IPE_IDX_G2_PEND: rd_nxt = {24'h0, g2_pend_r}; // RQ3
            `IPE_IDX_G0_EN_HI: rd_nxt = {24'h0, en_hi_r};
            `IPE_IDX_G0_EN_LO: rd_nxt = {24'h0, 1'b0, en_lo_r[6:0]}; // RQ11
            `IPE_IDX_CTRL: rd_nxt = {31'h0, gie_r};
            `IPE_IDX_STAT: rd_nxt = {28'h0, vec_req_r, 3'h0};
            `IPE_IDX_VEC: rd_nxt = {25'h0, vec_r};
            `IPE_IDX_IRQ_STAT: rd_nxt = {29'h0, ev_stat_r};
            `IPE_IDX_IRQ_EN: rd_nxt = {29'h0, ev_en_r};
            default: rd_nxt = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_r <= 32'h0000_0000;
      end else begin
         rd_r <= rd_nxt;
      end
   end
   assign prdata = rd_en ? rd_r : 32'h0000_0000;
   assign vec_req = vec_req_r;
   assign vec_info = vec_r;
   assign irq = |(ev_stat_r & ev_en_r);
endmodule

// ==== design/ipe_pkg.sv ====
// Types shared by the pending and priority enable block.
// Assumes the consts header is included alongside.
package ipe_pkg;
   typedef enum logic [1:0] {
      IPE_LVL_OFF = 2'b00,
      IPE_LVL_LOW = 2'b01,
      IPE_LVL_NOM = 2'b10,
      IPE_LVL_HIGH = 2'b11
   } ipe_level_e;
   typedef struct packed {
      logic valid;
      logic [3:0] source;
      ipe_level_e level;
   } ipe_vec_s;
   typedef struct packed {
      logic [13:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } ipe_apb_req_s;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ipe_apb_rsp_s;
endpackage

// ==== design/ipe_prio_pick.sv ====
// Priority picker over group-0 sources.
// Assumes pending and enable bytes come from same-clock registers.
`timescale 1ns/10ps
module ipe_prio_pick #(
   parameter int N = 8
) (
   input wire logic [N-1:0] pend,
   input wire logic [N-1:0] en_hi,
   input wire logic [N-1:0] en_lo,
   output ipe_pkg::ipe_vec_s pick
);
   import ipe_pkg::*;
   initial begin
      if (N < 1 || N > 16) begin
         $error("ipe_prio_pick: N out of range");
      end
   end
   logic [1:0] lvl [N];
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_lvl
         assign lvl[g] = pend[g] ? {en_hi[g], en_lo[g]} : 2'b00; // RQ6
      end
   endgenerate
   always_comb begin
      pick = '0;
      // Higher level wins; ties go to the higher bit number
      for (int i = 0; i < N; i++) begin
         if (lvl[i] != 2'b00 && (!pick.valid || lvl[i] >= pick.level)) begin // RQ7 RQ14
            pick.valid = 1'b1;
            pick.source = 4'(i);
            pick.level = ipe_level_e'(lvl[i]);
         end
      end
   end
endmodule

// ==== tb/ipe_core_model.sv ====
// Core model that takes vectored requests and acknowledges them.
// Assumes vec_req stands until acknowledged, same clock as the block.
`timescale 1ns/10ps
module ipe_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic vec_req,
   input wire logic [3:0] lag,
   output logic vec_ack
);
   logic [3:0] cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
         vec_ack <= 1'b0;
      end else if (vec_ack) begin
         cnt_r <= 4'h0;
         vec_ack <= 1'b0;
      end else if (vec_req) begin
         if (cnt_r >= lag) vec_ack <= 1'b1;
         else cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule

// ==== tb/ipe_irq_ctrl_chk.sv ====
// Port checker for the pending and priority enable block.
// Assumes the consts header and a bind onto ipe_irq_ctrl.
`timescale 1ns/10ps
`include "ipe_consts.svh"
module ipe_irq_ctrl_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic vec_ack,
   input wire logic vec_req,
   input wire ipe_pkg::ipe_vec_s vec_info,
   input wire logic irq
);
   import ipe_pkg::*;
   localparam logic [13:0] A_LO = {`IPE_IDX_G0_EN_LO, 2'b00};
   localparam logic [13:0] A_G2 = {`IPE_IDX_G2_PEND, 2'b00};
   logic rd_acc;
   assign rd_acc = psel && penable && !pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_stand; vec_req && !vec_ack |=> vec_req && $stable(vec_info); endproperty
   a_stand: assert property (p_stand) else $error("Vector dropped before ack");
   property p_gap; vec_req && vec_ack |=> !vec_req; endproperty
   a_gap: assert property (p_gap) else $error("New vector right after ack");
   property p_valid; vec_req |-> vec_info.valid; endproperty
   a_valid: assert property (p_valid) else $error("Vector without valid");
   property p_lvl; vec_req |-> vec_info.level != IPE_LVL_OFF; endproperty
   a_lvl: assert property (p_lvl) else $error("Disabled source vectored");
   property p_src; vec_req |-> vec_info.source inside {4'h6, 4'h5, 4'h4, 4'h3, 4'h0}; endproperty
   a_src: assert property (p_src) else $error("Vector from unassigned bit");
   property p_lo7; rd_acc && paddr == A_LO |-> prdata[7] == 1'b0 && prdata[2:1] == 2'h0; endproperty
   a_lo7: assert property (p_lo7) else $error("Low enable reserved bit read set");
   property p_g2; rd_acc && paddr == A_G2 |-> prdata[31:4] == 28'h0; endproperty
   a_g2: assert property (p_g2) else $error("Pending upper bits read set");
   property p_rst; $rose(presetn) |-> !vec_req && !irq; endproperty
   a_rst: assert property (p_rst) else $error("Outputs set after reset");
endmodule
bind ipe_irq_ctrl ipe_irq_ctrl_chk ipe_irq_ctrl_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .vec_ack(vec_ack),
   .vec_req(vec_req), .vec_info(vec_info), .irq(irq));

// ==== tb/test_irq_pending_and_priority_enable.sv ====
// Testbench for the pending and priority enable block.
// Assumes the core model and checker files are compiled before it.
`timescale 1ns/10ps
`include "ipe_consts.svh"
module test_irq_pending_and_priority_enable;
   import ipe_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   ipe_apb_req_s req = '0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, vec_ack, vec_req, irq;
   logic [3:0] pc = 4'h0;
   logic [3:0] lag = 4'h5;
   logic [7:0] g0 = 8'h00;
   ipe_vec_s vec_info;
   logic [5:0] got [$];
   int num_errors = 0;
   int n_compared = 0;
   localparam logic [28:0] ROWS [7] = '{{`IPE_IDX_G0_EN_HI, 8'h79, 8'h79, 1'b0},
      {`IPE_IDX_G0_EN_LO, 8'h81, 8'h01, 1'b0}, {`IPE_IDX_G0_EN_LO, 8'h78, 8'h78, 1'b0},
      {`IPE_IDX_G0_EN_HI, 8'h40, 8'h40, 1'b0}, {`IPE_IDX_G2_PEND, 8'h0a, 8'h0a, 1'b0},
      {`IPE_IDX_G2_PEND, 8'h00, 8'h00, 1'b0}, {12'h000, 8'h5a, 8'h00, 1'b1}};
   localparam logic [5:0] EXPV [3] = '{6'h13, 6'h02, 6'h19};
   always #2.5 pclk = ~pclk;
   ipe_irq_ctrl ipe_irq_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(req.psel), .penable(req.penable),
      .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .portc_pin_request(pc), .group0_source_request(g0), .vec_ack(vec_ack),
      .vec_req(vec_req), .vec_info(vec_info), .irq(irq));
   ipe_core_model ipe_core_model_inst (.pclk(pclk), .presetn(presetn), .vec_req(vec_req), .lag(lag),
      .vec_ack(vec_ack));
   always @(posedge pclk) if (vec_req === 1'b1 && vec_ack === 1'b1) got.push_back({vec_info.source, vec_info.level});
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] i, input logic [7:0] d);
      @(posedge pclk);
      req <= '{{i, 2'b00}, 1'b1, 1'b0, w, {24'h0, d}};
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      req <= '0;
   endtask
   task automatic rd(input logic [11:0] i, input logic [7:0] e);
      apb(1'b0, i, 8'h00);
      chk(rdat, {24'h0, e});
   endtask
   task automatic end_of_test();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      end_of_test();
   end
   initial begin
      logic [28:0] r;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(`IPE_IDX_G0_EN_HI, 8'h00);
      rd(`IPE_IDX_G0_EN_LO, 8'h00);
      rd(`IPE_IDX_G2_PEND, 8'h00);
      for (int i = 0; i < 7; i++) begin
         r = ROWS[i];
         apb(1'b1, r[28:17], r[16:9]);
         rd(r[28:17], r[8:1]);
         chk({31'h0, rerr}, {31'h0, r[0]});
      end
      for (int i = 0; i < 4; i++) begin
         pc <= 4'h1 << i;
         repeat (5) @(posedge pclk);
         rd(`IPE_IDX_G2_PEND, 8'h01 << i);
         pc <= 4'h0;
         apb(1'b1, `IPE_IDX_G2_PEND, 8'h00);
      end
      apb(1'b1, `IPE_IDX_G0_EN_HI, 8'h11);
      apb(1'b1, `IPE_IDX_G0_EN_LO, 8'h50);
      g0 <= 8'h71;
      repeat (5) @(posedge pclk);
      rd(`IPE_IDX_G0_PEND, 8'h71);
      chk({31'h0, vec_req}, 32'h0);
      apb(1'b1, `IPE_IDX_CTRL, 8'h01);
      for (int k = 0; k < 200 && got.size() < 3; k++) @(posedge pclk);
      repeat (20) @(posedge pclk);
      chk(got.size(), 32'h3);
      for (int k = 0; k < 3; k++) chk({26'h0, got[k]}, {26'h0, EXPV[k]});
      rd(`IPE_IDX_G0_PEND, 8'h20);
      apb(1'b1, `IPE_IDX_IRQ_EN, 8'h02);
      pc <= 4'h8;
      repeat (5) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      pc <= 4'h0;
      apb(1'b1, `IPE_IDX_IRQ_EN, 8'h00);
      apb(1'b1, `IPE_IDX_G2_PEND, 8'h00);
      apb(1'b1, `IPE_IDX_IRQ_CLR, 8'h02);
      pc <= 4'h4;
      repeat (5) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `IPE_IDX_IRQ_EN, 8'h02);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      end_of_test();
   end
endmodule
